// >>> inc/dsac_consts.svh
// offsets, field positions, reset values and contract for the speed assembly codec
`ifndef DSAC_CONSTS_SVH
`define DSAC_CONSTS_SVH

`define DSAC_INST_BASIC_OUT 8'h14
`define DSAC_INST_EXT_OUT   8'h15
`define DSAC_INST_BASIC_IN  8'h46

`define DSAC_B_RUN_FWD  0
`define DSAC_B_RUN_REV  1
`define DSAC_B_FLT_RST  2
`define DSAC_B_NET_CTRL 5
`define DSAC_B_NET_REF  6
`define DSAC_B_FAULTED  0
`define DSAC_B_RUN_1FWD 2

`define DSAC_REG_CTRL     8'h00
`define DSAC_REG_STATUS   8'h04
`define DSAC_REG_IRQ_STAT 8'h08
`define DSAC_REG_IRQ_MASK 8'h0C
`define DSAC_REG_SPD_REF  8'h10
`define DSAC_REG_SPD_ACT  8'h14

`define DSAC_CTRL_RUN_SRC 0
`define DSAC_CTRL_REF_SRC 1
`define DSAC_CTRL_SS_LSB  4
`define DSAC_CTRL_DU_LSB  8
`define DSAC_CTRL_RST     32'h0000_0000

`define DSAC_IRQ_ACCEPT 0
`define DSAC_IRQ_REJECT 1
`define DSAC_IRQ_FLTRST 2
`define DSAC_IRQ_FAULT  3
`define DSAC_IRQ_W      4

`define DSAC_SPD_MAX 32'h0000_FFFF

`endif

// >>> inc/dsac_pkg.sv
// types and shared arithmetic of the speed assembly codec
package dsac_pkg;

	typedef struct packed {
		logic        valid;
		logic [7:0]  inst;
		logic [31:0] data;
	} dsac_frame_t;

	typedef struct packed {
		logic        fault;
		logic        run_fwd;
		logic        run_rev;
		logic [31:0] freq;
	} dsac_core_t;

	typedef struct packed {
		logic        run_fwd;
		logic        run_rev;
		logic        fault_reset;
		logic        run_from_link;
		logic        ref_from_link;
		logic [31:0] speed_ref;
	} dsac_cmd_t;

	// multiply by two to a signed exponent
	function automatic logic [31:0] dsac_scale(input logic [31:0] v, input logic signed [3:0] ss);
		logic [3:0] mag;
		mag = ss[3] ? 4'((~ss) + 4'h1) : ss;
		if (ss[3]) begin
			return v >> mag;
		end
		return v << mag;
	endfunction

endpackage

// >>> rtl/dsac_codec.sv
// speed control output assembly decoder and basic input assembly encoder
`timescale 1ns/100ps
`include "dsac_consts.svh"

module dsac_codec
	import dsac_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// link side
	input  wire dsac_frame_t link_rx,
	output logic [31:0]      link_tx_data,
	output logic [7:0]       link_tx_inst,
	// drive core side
	input  wire dsac_core_t  core_in,
	output dsac_cmd_t        cmd,
	output logic [3:0]       display_unit,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// interrupt
	output logic             irq
);

	logic [31:0]             ctrl_reg;
	logic [`DSAC_IRQ_W-1:0]  irq_stat_reg;
	logic [`DSAC_IRQ_W-1:0]  irq_mask_reg;
	logic [`DSAC_IRQ_W-1:0]  irq_set;
	logic [31:0]             rdata_reg;
	logic [31:0]             tx_reg;
	logic [7:0]              last_inst_reg;
	logic                    fault_prev_reg;
	logic                    net_ctrl_reg;
	logic                    net_ref_reg;
	logic                    run_fwd_reg;
	logic                    run_rev_reg;
	logic                    fault_reset_reg;
	logic [31:0]             speed_ref_reg;
	logic [47:0]             act_wide;
	logic                    is_basic;
	logic                    is_ext;
	logic                    take;
	logic                    run_src_param;
	logic                    ref_src_param;
	logic signed [3:0]       speed_scale;
	logic [15:0]             ref_field;
	logic [31:0]             act_scaled;
	logic [15:0]             act_field;
	logic                    fwd_state;

	// register write decode
	function automatic logic wr_hit(input logic [7:0] target);
		return reg_wr && (reg_addr == target);
	endfunction

	assign run_src_param = ctrl_reg[`DSAC_CTRL_RUN_SRC];
	assign ref_src_param = ctrl_reg[`DSAC_CTRL_REF_SRC];
	assign speed_scale   = ctrl_reg[`DSAC_CTRL_SS_LSB +: 4];

	assign display_unit  = ctrl_reg[`DSAC_CTRL_DU_LSB +: 4];

	assign is_basic = link_rx.inst == `DSAC_INST_BASIC_OUT;

	assign is_ext   = link_rx.inst == `DSAC_INST_EXT_OUT;

	assign take     = link_rx.valid && (is_basic || is_ext);

	// low byte 2, high byte 3
	assign ref_field = {link_rx.data[31:24], link_rx.data[23:16]};

	// actual times two to the scale
	assign act_scaled = dsac_scale(core_in.freq, speed_scale);

	// left shifts kept wide so overflow saturates
	assign act_wide  = speed_scale[3] ? {16'h0000, act_scaled} : ({16'h0000, core_in.freq} << speed_scale[2:0]);

	assign act_field = (act_wide > 48'h0000_0000_FFFF) ? 16'hFFFF : act_wide[15:0];

	assign fwd_state = core_in.run_fwd && !core_in.run_rev;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_fwd_reg <= 1'b0;
		end else if (take) begin
			run_fwd_reg <= link_rx.data[`DSAC_B_RUN_FWD];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			run_rev_reg <= 1'b0;
		end else if (take) begin
			run_rev_reg <= is_ext && link_rx.data[`DSAC_B_RUN_REV];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_reset_reg <= 1'b0;
		end else begin
			fault_reset_reg <= take && link_rx.data[`DSAC_B_FLT_RST];
		end
	end

	// link source bits held from last frame
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			net_ctrl_reg <= 1'b0;
			net_ref_reg  <= 1'b0;
		end else if (take) begin
			net_ctrl_reg <= is_ext && link_rx.data[`DSAC_B_NET_CTRL];
			net_ref_reg  <= is_ext && link_rx.data[`DSAC_B_NET_REF];
		end
	end

	assign cmd.run_from_link = net_ctrl_reg || run_src_param;

	assign cmd.ref_from_link = net_ref_reg || ref_src_param;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			speed_ref_reg <= 32'h0000_0000;
		end else if (take) begin
			speed_ref_reg <= dsac_scale({16'h0000, ref_field}, speed_scale);
		end
	end

	assign cmd.run_fwd     = run_fwd_reg;
	assign cmd.run_rev     = run_rev_reg;
	assign cmd.fault_reset = fault_reset_reg;
	assign cmd.speed_ref   = speed_ref_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			last_inst_reg <= 8'h00;
		end else if (take) begin
			last_inst_reg <= link_rx.inst;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_reg <= 32'h0000_0000;
		end else begin
			tx_reg                   <= 32'h0000_0000;
			tx_reg[`DSAC_B_FAULTED]  <= core_in.fault;
			tx_reg[`DSAC_B_RUN_1FWD] <= fwd_state;
			tx_reg[31:16]            <= act_field;
		end
	end

	assign link_tx_data = tx_reg;
	assign link_tx_inst = `DSAC_INST_BASIC_IN;

	// events
	always_comb begin
		irq_set                   = '0;
		irq_set[`DSAC_IRQ_ACCEPT] = take;
		irq_set[`DSAC_IRQ_REJECT] = link_rx.valid && !is_basic && !is_ext;
		irq_set[`DSAC_IRQ_FLTRST] = take && link_rx.data[`DSAC_B_FLT_RST];
		irq_set[`DSAC_IRQ_FAULT]  = core_in.fault && !fault_prev_reg;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fault_prev_reg <= 1'b0;
		end else begin
			fault_prev_reg <= core_in.fault;
		end
	end

	// sticky status, set wins over write-one clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_reg <= '0;
		end else if (wr_hit(`DSAC_REG_IRQ_STAT)) begin
			irq_stat_reg <= (irq_stat_reg & ~reg_wdata[`DSAC_IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_set;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask_reg <= '0;
		end else if (wr_hit(`DSAC_REG_IRQ_MASK)) begin
			irq_mask_reg <= reg_wdata[`DSAC_IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= `DSAC_CTRL_RST;
		end else if (wr_hit(`DSAC_REG_CTRL)) begin
			ctrl_reg <= {20'h00000, reg_wdata[11:4], 2'b00, reg_wdata[1:0]};
		end
	end

	// read data one cycle after strobe, zero elsewhere
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (!reg_rd) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			case (reg_addr)
				`DSAC_REG_CTRL:     rdata_reg <= ctrl_reg;
				`DSAC_REG_STATUS:   rdata_reg <= {16'h0000, last_inst_reg, 3'b000,
					cmd.ref_from_link, cmd.run_from_link, fwd_state,
					cmd.run_fwd, core_in.fault};
				`DSAC_REG_IRQ_STAT: rdata_reg <= {28'h0000000, irq_stat_reg};
				`DSAC_REG_IRQ_MASK: rdata_reg <= {28'h0000000, irq_mask_reg};
				`DSAC_REG_SPD_REF:  rdata_reg <= speed_ref_reg;
				`DSAC_REG_SPD_ACT:  rdata_reg <= {16'h0000, tx_reg[31:16]};
				default:            rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	assign reg_rdata = rdata_reg;

	AST_BASIC_FWD: assert property (@(posedge clk) disable iff (!arst_n)
		link_rx.valid && is_basic |=> cmd.run_fwd == $past(link_rx.data[0]) && !cmd.run_rev)
		else $error("basic frame run bits wrong");

	AST_EXT_REV: assert property (@(posedge clk) disable iff (!arst_n)
		link_rx.valid && is_ext |=> cmd.run_rev == $past(link_rx.data[1]))
		else $error("reverse run not taken");

	AST_FLT_PULSE: assert property (@(posedge clk) disable iff (!arst_n)
		take && link_rx.data[2] |=> cmd.fault_reset ##1 (!cmd.fault_reset || $past(take && link_rx.data[2])))
		else $error("fault reset pulse wrong");

	AST_RUN_SRC: assert property (@(posedge clk) disable iff (!arst_n)
		take && is_ext && !link_rx.data[5] |=> cmd.run_from_link == run_src_param)
		else $error("run source not from parameter");

	AST_REF_SRC: assert property (@(posedge clk) disable iff (!arst_n)
		take && is_ext && link_rx.data[6] |=> cmd.ref_from_link)
		else $error("reference source not link");

	AST_REF_VAL: assert property (@(posedge clk) disable iff (!arst_n)
		take && speed_scale == 4'sh0 |=> cmd.speed_ref == {16'h0000, $past(link_rx.data[31:16])})
		else $error("speed reference value wrong");

	AST_REJECT: assert property (@(posedge clk) disable iff (!arst_n)
		link_rx.valid && !take |=> $stable(cmd.speed_ref) && irq_stat_reg[1])
		else $error("unknown instance changed state");

	AST_FAULTED: assert property (@(posedge clk) disable iff (!arst_n)
		##1 link_tx_data[0] == $past(core_in.fault))
		else $error("faulted flag wrong");

	AST_FWD_FLAG: assert property (@(posedge clk) disable iff (!arst_n)
		core_in.run_rev |=> !link_tx_data[2])
		else $error("forward flag set in reverse");

	AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
		link_tx_data[15:3] == 13'h0000 && !link_tx_data[1])
		else $error("reserved input bits not zero");

	AST_ACT_VAL: assert property (@(posedge clk) disable iff (!arst_n)
		speed_scale == 4'sh2 && core_in.freq < 32'h0000_4000
		|=> link_tx_data[31:16] == 16'($past(core_in.freq) << 2))
		else $error("actual speed scaling wrong");

	AST_FLT_VAL: assert property (@(posedge clk) disable iff (!arst_n)
		take |=> cmd.fault_reset == $past(link_rx.data[`DSAC_B_FLT_RST]))
		else $error("fault reset not taken from frame");

	AST_FLT_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
		!take |=> !cmd.fault_reset)
		else $error("fault reset without frame");

	AST_EXT_FWD: assert property (@(posedge clk) disable iff (!arst_n)
		link_rx.valid && is_ext |=> cmd.run_fwd == $past(link_rx.data[`DSAC_B_RUN_FWD]))
		else $error("forward run not taken from extended frame");

	AST_RUN_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
		!take |=> $stable(cmd.run_fwd) && $stable(cmd.run_rev))
		else $error("run command changed without frame");

	AST_BASIC_REV0: assert property (@(posedge clk) disable iff (!arst_n)
		take && is_basic |=> !cmd.run_rev)
		else $error("reverse run after basic frame");

	AST_BASIC_SRC: assert property (@(posedge clk) disable iff (!arst_n)
		take && is_basic |=> cmd.run_from_link == run_src_param && cmd.ref_from_link == ref_src_param)
		else $error("basic frame sources not from parameters");

	AST_RUN_LINK: assert property (@(posedge clk) disable iff (!arst_n)
		take && is_ext && link_rx.data[`DSAC_B_NET_CTRL] |=> cmd.run_from_link)
		else $error("run source not link");

	AST_REF_PARAM: assert property (@(posedge clk) disable iff (!arst_n)
		take && is_ext && !link_rx.data[`DSAC_B_NET_REF] |=> cmd.ref_from_link == ref_src_param)
		else $error("reference source not from parameter");

	AST_REF_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
		!take |=> $stable(cmd.speed_ref))
		else $error("speed reference changed without frame");

	AST_REF_SCALE2: assert property (@(posedge clk) disable iff (!arst_n)
		take && speed_scale == 4'sh2 |=> cmd.speed_ref == {14'h0000, $past(link_rx.data[31:16]), 2'b00})
		else $error("speed reference rescale wrong");

	AST_REF_BYTES: assert property (@(posedge clk) disable iff (!arst_n)
		take && speed_scale == 4'sh0 |=> cmd.speed_ref[7:0] == $past(link_rx.data[23:16]))
		else $error("speed reference low byte wrong");

	AST_REF_RANGE: assert property (@(posedge clk) disable iff (!arst_n)
		take && speed_scale == 4'sh0 |=> cmd.speed_ref[31:16] == 16'h0000)
		else $error("unscaled reference above 16 bits");

	AST_REJ_RUN: assert property (@(posedge clk) disable iff (!arst_n)
		link_rx.valid && !take |=> $stable(cmd.run_fwd) && $stable(cmd.run_rev))
		else $error("unknown instance changed run command");

	AST_FAULT_SET: assert property (@(posedge clk) disable iff (!arst_n)
		core_in.fault |=> link_tx_data[`DSAC_B_FAULTED])
		else $error("faulted flag missing");

	AST_FAULT_CLR: assert property (@(posedge clk) disable iff (!arst_n)
		!core_in.fault |=> !link_tx_data[`DSAC_B_FAULTED])
		else $error("faulted flag without fault");

	AST_FWD_SET: assert property (@(posedge clk) disable iff (!arst_n)
		core_in.run_fwd && !core_in.run_rev |=> link_tx_data[`DSAC_B_RUN_1FWD])
		else $error("forward flag missing");

	AST_FWD_STOP: assert property (@(posedge clk) disable iff (!arst_n)
		!core_in.run_fwd |=> !link_tx_data[`DSAC_B_RUN_1FWD])
		else $error("forward flag while stopped");

	AST_ACT_DIRECT: assert property (@(posedge clk) disable iff (!arst_n)
		speed_scale == 4'sh0 && core_in.freq < 32'h0001_0000
		|=> link_tx_data[31:16] == $past(core_in.freq[15:0]))
		else $error("actual speed not output frequency");

	AST_ACT_SAT: assert property (@(posedge clk) disable iff (!arst_n)
		core_in.freq > `DSAC_SPD_MAX && !speed_scale[3] |=> link_tx_data[31:16] == 16'hFFFF)
		else $error("actual speed not saturated");

	AST_ACT_BYTES: assert property (@(posedge clk) disable iff (!arst_n)
		speed_scale == 4'sh0 && core_in.freq < 32'h0001_0000
		|=> link_tx_data[23:16] == $past(core_in.freq[7:0]))
		else $error("actual speed low byte wrong");

	AST_ACCEPT_EVT: assert property (@(posedge clk) disable iff (!arst_n)
		take |=> irq_stat_reg[`DSAC_IRQ_ACCEPT])
		else $error("accept event lost");

	AST_FLTRST_EVT: assert property (@(posedge clk) disable iff (!arst_n)
		take && link_rx.data[`DSAC_B_FLT_RST] |=> irq_stat_reg[`DSAC_IRQ_FLTRST])
		else $error("fault reset event lost");

	AST_FAULT_EVT: assert property (@(posedge clk) disable iff (!arst_n)
		core_in.fault && !fault_prev_reg |=> irq_stat_reg[`DSAC_IRQ_FAULT])
		else $error("fault event lost");

endmodule

// >>> tb/dsac_ctrl_model.sv
// network controller model that sends one output frame per bench request
`timescale 1ns/100ps

module dsac_ctrl_model
	import dsac_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// frame request from the bench
	input  wire logic        send,
	input  wire logic [7:0]  s_inst,
	input  wire logic [31:0] s_data,
	// link towards the device
	output dsac_frame_t      link_rx
);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			link_rx <= '0;
		end else if (send) begin
			link_rx <= {1'h1, s_inst, s_data};
		end else begin
			link_rx <= {1'h0, ~link_rx.inst, ~link_rx.data};
		end
	end
endmodule

// >>> tb/tb_drive_speed_assembly_codec.sv
// self-checking bench for the speed assembly codec
`timescale 1ns/100ps
`include "dsac_consts.svh"

module tb_drive_speed_assembly_codec
	import dsac_pkg::*;
;
	logic        clk = 1'h0;
	logic        arst_n = 1'h0;
	logic        send = 1'h0;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic [7:0]  s_inst = 8'h00;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] s_data = 32'h0000_0000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	dsac_core_t  core_in = '0;
	dsac_frame_t link_rx;
	dsac_cmd_t   cmd;
	logic [31:0] link_tx_data;
	logic [31:0] reg_rdata;
	logic [7:0]  link_tx_inst;
	logic [3:0]  display_unit;
	logic        irq;
	int          n_errors = 0;
	int          checked = 0;
	int          cycles = 0;

	always #12.5 clk = ~clk;

	dsac_ctrl_model i_dsac_ctrl_model (.clk(clk), .arst_n(arst_n), .send(send), .s_inst(s_inst),
		.s_data(s_data), .link_rx(link_rx));

	dsac_codec i_dsac_codec (.clk(clk), .arst_n(arst_n), .link_rx(link_rx), .link_tx_data(link_tx_data),
		.link_tx_inst(link_tx_inst), .core_in(core_in), .cmd(cmd), .display_unit(display_unit),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr    <= 1'h1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
		#1;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		reg_rd   <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		chk(reg_rdata, exp, what);
	endtask

	task automatic frame(input logic [7:0] i, input logic [31:0] d);
		@(posedge clk);
		send   <= 1'h1;
		s_inst <= i;
		s_data <= d;
		@(posedge clk);
		send <= 1'h0;
		@(posedge clk);
		#1;
	endtask

	task automatic core(input dsac_core_t c, input logic [31:0] exp, input string what);
		@(posedge clk);
		core_in <= c;
		repeat (2) @(posedge clk);
		#1;
		chk(link_tx_data, exp, what);
	endtask

	function automatic logic [31:0] flags();
		return {27'h0, cmd.run_fwd, cmd.run_rev, cmd.fault_reset, cmd.run_from_link, cmd.ref_from_link};
	endfunction

	// cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			end_of_test();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		arst_n <= 1'h1;
		#1;
		chk({24'h0, link_tx_inst}, 32'h0000_0046, "input instance");
		rd_chk(`DSAC_REG_CTRL, 32'h0000_0000, "ctrl reset");
		rd_chk(8'h40, 32'h0000_0000, "unmapped read");
		wr(`DSAC_REG_IRQ_MASK, 32'h0000_000F);
		$display("reset and registers done");

		frame(`DSAC_INST_EXT_OUT, 32'h0400_0063);
		chk(flags(), 32'h0000_001B, "ext flags");
		chk(cmd.speed_ref, 32'h0000_0400, "ext ref");
		chk({31'h0, irq}, 32'h0000_0001, "accept irq");
		wr(`DSAC_REG_IRQ_STAT, 32'h0000_000F);
		chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
		wr(`DSAC_REG_CTRL, 32'h0000_0020);
		frame(`DSAC_INST_BASIC_OUT, 32'h0400_FFFD);
		chk(flags(), 32'h0000_0014, "basic flags");
		chk(cmd.speed_ref, 32'h0000_1000, "scaled ref");
		@(posedge clk);
		#1;
		chk({31'h0, cmd.fault_reset}, 32'h0000_0000, "reset pulse end");
		$display("output frames done");

		wr(`DSAC_REG_CTRL, 32'h0000_0501);
		chk({28'h0, display_unit}, 32'h0000_0005, "display unit");
		frame(`DSAC_INST_EXT_OUT, 32'hFFFF_0000);
		chk(flags(), 32'h0000_0002, "param sources");
		chk(cmd.speed_ref, 32'h0000_FFFF, "full ref");
		frame(`DSAC_INST_BASIC_IN, 32'h0000_0001);
		chk(flags(), 32'h0000_0002, "rejected flags");
		chk(cmd.speed_ref, 32'h0000_FFFF, "rejected ref");
		rd_chk(`DSAC_REG_SPD_REF, 32'h0000_FFFF, "ref register");
		rd_chk(`DSAC_REG_IRQ_STAT, 32'h0000_0007, "irq status");
		wr(`DSAC_REG_IRQ_MASK, 32'h0000_0002);
		chk({31'h0, irq}, 32'h0000_0001, "reject irq");
		wr(`DSAC_REG_IRQ_STAT, 32'h0000_0002);
		chk({31'h0, irq}, 32'h0000_0000, "masked irq");
		$display("sources and refusal done");

		wr(`DSAC_REG_CTRL, 32'h0000_0020);
		core(dsac_core_t'{1'h1, 1'h1, 1'h0, 32'h0000_0400}, 32'h1000_0005, "fwd fault");
		rd_chk(`DSAC_REG_IRQ_STAT, 32'h0000_000D, "fault event");
		rd_chk(`DSAC_REG_STATUS, 32'h0000_1505, "status register");
		rd_chk(`DSAC_REG_SPD_ACT, 32'h0000_1000, "actual register");
		core(dsac_core_t'{1'h0, 1'h1, 1'h1, 32'h0000_0400}, 32'h1000_0000, "reverse");
		core(dsac_core_t'{1'h0, 1'h0, 1'h0, 32'h4000_0000}, 32'hFFFF_0000, "clamped");
		$display("input instance done");
		end_of_test();
	end
endmodule
